// [core/bert_aux_io.sv]
// Generator and analyzer auxiliary signal logic with a Wishbone classic register slave.
// Assumes all pin inputs are asynchronous to clk_i; link clock is sampled and edge detected.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/10ps
module bert_aux_io
    import bert_pkg::*;
#(
    parameter int DLY_DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    // Generator pins
    input wire logic fault_inject_i,
    input wire logic data_inhibit_i,
    output tx_pins_t tx_o,
    // Analyzer pins
    input wire logic rx_clk_i,
    input wire logic rx_data_i,
    input wire logic rx_ref_i,
    input wire logic error_inhibit_i,
    output rx_pins_t rx_o
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic invert;
        logic external_fault_insert_mode;
        logic ext_ref;
        logic [15:0] div;
        logic [DLY_W-1:0] ddly;
        logic [DLY_W-1:0] rdly;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic [31:0] errcnt;
        logic [15:0] divcnt;
        logic tx_clk;
        logic clk2;
        logic clk4;
        logic parity;
        logic inj_pend;
        tx_pins_t tx;
        logic [1:0] inj_s;
        logic inj_prev;
        logic [1:0] dinh_s;
        logic [1:0] einh_s;
        logic [1:0] rclk_s;
        logic [1:0] rdat_s;
        logic [1:0] rref_s;
        logic rclk_prev;
        logic [DLY_DEPTH-1:0] dline;
        logic [DLY_DEPTH-1:0] rline;
        rx_pins_t rx;
    } st_t;

    st_t st;
    st_t next_st;

    logic gen_bit;
    logic gen_frame;
    logic rx_pred;
    logic rx_frame;
    logic rx_edge;
    logic half_en;
    logic bit_en;
    logic rx_bit;
    logic ref_bit;
    logic mismatch;
    logic wb_req;

    // Byte-lane merge of a write into a register word
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    // Data advances when the test clock falls, so each bit is centred on the rising edge
    assign half_en = (st.divcnt == 16'h0000);
    assign bit_en = half_en && st.tx_clk;
    assign rx_edge = st.rclk_s[1] && !st.rclk_prev;
    assign rx_bit = st.dline[st.ddly];
    assign ref_bit = st.rline[st.rdly];
    assign mismatch = rx_bit != (st.ext_ref ? ref_bit : rx_pred);
    assign wb_req = cyc_i && stb_i && !st.ack;

    prbs_lfsr #(
        .W(PRBS_W)
    ) u_gen_lfsr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(bit_en),
        .use_in_i(1'b0),
        .shift_in_i(1'b0),
        .bit_o(gen_bit),
        .frame_o(gen_frame)
    );

    // Received bits feed the reference register so it locks to the incoming pattern
    prbs_lfsr #(
        .W(PRBS_W)
    ) u_rx_lfsr (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .step_i(rx_edge),
        .use_in_i(1'b1),
        .shift_in_i(rx_bit),
        .bit_o(rx_pred),
        .frame_o(rx_frame)
    );

    always_comb begin
        logic [EV_W-1:0] ev_set;
        logic [EV_W-1:0] ev_clr;
        logic [31:0] wval;
        logic flip;
        logic dbit;
        ev_set = '0;
        ev_clr = '0;
        wval = 32'h0000_0000;
        flip = 1'b0;
        dbit = 1'b0;
        next_st = st;

        // Two-stage synchronisers for every pin input
        next_st.inj_s = {st.inj_s[0], fault_inject_i};
        next_st.dinh_s = {st.dinh_s[0], data_inhibit_i};
        next_st.einh_s = {st.einh_s[0], error_inhibit_i};
        next_st.rclk_s = {st.rclk_s[0], rx_clk_i};
        next_st.rdat_s = {st.rdat_s[0], rx_data_i};
        next_st.rref_s = {st.rref_s[0], rx_ref_i};
        next_st.inj_prev = st.inj_s[1];
        next_st.rclk_prev = st.rclk_s[1];

        // Generator bit-rate divider
        next_st.divcnt = half_en ? ((st.div == 16'h0000) ? 16'h0000 : st.div - 16'h0001)
                                 : st.divcnt - 16'h0001;
        if (half_en) begin
            next_st.tx_clk = !st.tx_clk;
        end

        // Inject edge is remembered until the next bit boundary; a new edge wins over the clear
        if (bit_en && st.inj_pend) begin
            next_st.inj_pend = 1'b0;
        end
        if (st.inj_s[1] && !st.inj_prev && st.external_fault_insert_mode) begin
            next_st.inj_pend = 1'b1;
        end

        if (bit_en) begin
            flip = st.inj_pend;
            ev_set[EV_INJECT] = st.inj_pend;
            dbit = gen_bit ^ st.invert ^ flip;
            next_st.tx.data = dbit;
            next_st.tx.data_n = !dbit;
            next_st.parity = !st.parity;
            if (!st.parity) begin
                next_st.tx.phase_a = dbit;
            end else begin
                next_st.tx.phase_b = dbit;
            end
            next_st.clk2 = !st.clk2;
            if (st.clk2) begin
                next_st.clk4 = !st.clk4;
            end
            next_st.tx.frame_sync = gen_frame;
        end
        // Inhibit holds every data output low for as long as it stands
        if (st.dinh_s[1]) begin
            next_st.tx.data = 1'b0;
            next_st.tx.data_n = 1'b0;
            next_st.tx.phase_a = 1'b0;
            next_st.tx.phase_b = 1'b0;
        end
        next_st.tx.clk = st.tx_clk;
        next_st.tx.clk_n = !st.tx_clk;
        next_st.tx.clk_div2 = st.clk2;
        next_st.tx.clk_div4 = st.clk4;

        // Analyzer delay lines, one tap per system clock
        next_st.dline = {st.dline[DLY_DEPTH-2:0], st.rdat_s[1]};
        next_st.rline = {st.rline[DLY_DEPTH-2:0], st.rref_s[1]};
        next_st.rx.mon_clk = st.rclk_s[1];
        next_st.rx.per_mismatch_pulse_out = 1'b0;
        next_st.rx.frame_sync = 1'b0;
        if (rx_edge) begin
            next_st.rx.mon_data = rx_bit;
            next_st.rx.frame_sync = rx_frame;
            ev_set[EV_RX_SYNC] = rx_frame;
            if (mismatch && !st.einh_s[1]) begin
                next_st.rx.per_mismatch_pulse_out = 1'b1;
                next_st.errcnt = st.errcnt + 32'h0000_0001;
                ev_set[EV_ERROR] = 1'b1;
            end
        end

        // Wishbone slave: answer one cycle after the request
        next_st.ack = wb_req;
        if (wb_req) begin
            next_st.rdata = 32'h0000_0000;
            unique case (adr_i)
                REG_CTRL: begin
                    next_st.rdata[CTRL_INVERT] = st.invert;
                    next_st.rdata[CTRL_EXTERNAL_FAULT_INSERT_MODE] = st.external_fault_insert_mode;
                    next_st.rdata[CTRL_EXT_REF] = st.ext_ref;
                    if (we_i) begin
                        wval = lane_merge(next_st.rdata, dat_i, sel_i);
                        next_st.invert = wval[CTRL_INVERT];
                        next_st.external_fault_insert_mode = wval[CTRL_EXTERNAL_FAULT_INSERT_MODE];
                        next_st.ext_ref = wval[CTRL_EXT_REF];
                    end
                end
                REG_DIV: begin
                    next_st.rdata[15:0] = st.div;
                    if (we_i) begin
                        wval = lane_merge({16'h0000, st.div}, dat_i, sel_i);
                        next_st.div = wval[15:0];
                    end
                end
                REG_DELAY: begin
                    next_st.rdata[DLY_DATA_LSB +: DLY_W] = st.ddly;
                    next_st.rdata[DLY_REF_LSB +: DLY_W] = st.rdly;
                    if (we_i) begin
                        wval = lane_merge(next_st.rdata, dat_i, sel_i);
                        next_st.ddly = wval[DLY_DATA_LSB +: DLY_W];
                        next_st.rdly = wval[DLY_REF_LSB +: DLY_W];
                    end
                end
                REG_STATUS: begin
                    next_st.rdata[EV_W-1:0] = st.status;
                    if (!we_i) begin
                        ev_clr = st.status;
                    end
                end
                REG_MASK: begin
                    next_st.rdata[EV_W-1:0] = st.mask;
                    if (we_i) begin
                        wval = lane_merge({29'h0000_0000, st.mask}, dat_i, sel_i);
                        next_st.mask = wval[EV_W-1:0];
                    end
                end
                REG_ERRCNT: begin
                    next_st.rdata = st.errcnt;
                    // An error counted in the clearing cycle survives the clear
                    if (we_i) begin
                        next_st.errcnt = {31'h0000_0000, ev_set[EV_ERROR]};
                    end
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
        end
        // Events arriving during a clearing read stay set
        next_st.status = (st.status & ~ev_clr) | ev_set;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.div <= DIV_RESET;
            st.mask <= MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign dat_o = st.rdata;
    assign ack_o = st.ack;
    assign irq_o = |(st.status & st.mask);
    assign tx_o = st.tx;
    assign rx_o = st.rx;
endmodule : bert_aux_io

// [core/bert_pkg.sv]
// Shared constants and carrier types for the bit error tester auxiliary I/O block.
// Assumes a Wishbone classic slave with 32-bit data and byte addresses.
package bert_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DIV = 8'h04;
    localparam logic [7:0] REG_DELAY = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_MASK = 8'h10;
    localparam logic [7:0] REG_ERRCNT = 8'h14;

    // Control register fields
    localparam int CTRL_INVERT = 0;
    localparam int CTRL_EXTERNAL_FAULT_INSERT_MODE = 1;
    localparam int CTRL_EXT_REF = 2;

    // Delay register fields
    localparam int DLY_DATA_LSB = 0;
    localparam int DLY_REF_LSB = 8;
    localparam int DLY_W = 4;

    // Status and mask bit positions
    localparam int EV_ERROR = 0;
    localparam int EV_RX_SYNC = 1;
    localparam int EV_INJECT = 2;
    localparam int EV_W = 3;

    // Reset values
    localparam logic [15:0] DIV_RESET = 16'h0001;
    localparam logic [EV_W-1:0] MASK_RESET = 3'h0;

    // Pattern generator
    localparam int PRBS_W = 7;

    // Generator pins toward the device under test
    typedef struct packed {
        logic data;
        logic data_n;
        logic clk;
        logic clk_n;
        logic phase_a;
        logic phase_b;
        logic clk_div2;
        logic clk_div4;
        logic frame_sync;
    } tx_pins_t;

    // Analyzer monitor and error pins
    typedef struct packed {
        logic mon_clk;
        logic mon_data;
        logic frame_sync;
        logic per_mismatch_pulse_out;
    } rx_pins_t;
endpackage : bert_pkg

// [core/prbs_lfsr.sv]
// Linear feedback shift register used as pattern source and as self-synchronising reference.
// Assumes step_i is a one-cycle enable on clk_i.
`timescale 1ns/10ps
module prbs_lfsr
    import bert_pkg::*;
#(
    parameter int W = PRBS_W
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic step_i,
    input wire logic use_in_i,
    input wire logic shift_in_i,
    output logic bit_o,
    output logic frame_o
);
    typedef struct packed {
        logic [W-1:0] sr;
    } lfsr_st_t;

    lfsr_st_t st;
    lfsr_st_t next_st;

    assign bit_o = st.sr[W-1] ^ st.sr[W-2];
    // All-ones marks the first bit of a frame
    assign frame_o = &st.sr;

    always_comb begin
        next_st = st;
        if (step_i) begin
            next_st.sr = {st.sr[W-2:0], use_in_i ? shift_in_i : bit_o};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st.sr <= '1;
        end else begin
            st <= next_st;
        end
    end
endmodule : prbs_lfsr

// [testbench/bert_aux_io_sva.sv]
// Concurrent checks on the auxiliary I/O block's ports.
// Assumes one clock domain, clk_i, with synchronous reset rst_i.
`timescale 1ns/10ps
module bert_aux_io_sva
    import bert_pkg::*;
#(
    parameter int DLY_DEPTH = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic data_inhibit_i,
    input wire logic error_inhibit_i,
    input wire logic rx_clk_i,
    input wire tx_pins_t tx_o,
    input wire rx_pins_t rx_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] warm;
    // Pipeline warm-up after reset before the monitor clock copy is valid
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            warm <= 2'h0;
        end else if (warm != 2'h3) begin
            warm <= warm + 2'h1;
        end
    end
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (req_s |=> ack_o)
        else $error("no ack one cycle after request");
    unmapped_zero_a: assert property (req_s and !we_i && adr_i > 8'h14 |=> dat_o == 32'h0)
        else $error("unmapped read gave nonzero data");
    data_gate_a: assert property (data_inhibit_i [*5] |-> !(tx_o.data | tx_o.phase_a | tx_o.phase_b))
        else $error("data output not gated while inhibited");
    err_gate_a: assert property (error_inhibit_i [*5] |-> !rx_o.per_mismatch_pulse_out)
        else $error("error pulse while counting inhibited");
    err_pulse_a: assert property (rx_o.per_mismatch_pulse_out |=> !rx_o.per_mismatch_pulse_out [*4])
        else $error("error pulse not return to zero");
    rx_sync_a: assert property (rx_o.frame_sync |=> !rx_o.frame_sync [*4])
        else $error("analyzer sync pulse too long");
    mon_clk_a: assert property (warm == 2'h3 |-> rx_o.mon_clk == $past(rx_clk_i, 3))
        else $error("monitor clock is not the received clock");
endmodule : bert_aux_io_sva
bind bert_aux_io bert_aux_io_sva #(.DLY_DEPTH(DLY_DEPTH)) sva_i (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .data_inhibit_i(data_inhibit_i), .error_inhibit_i(error_inhibit_i),
    .rx_clk_i(rx_clk_i), .tx_o(tx_o), .rx_o(rx_o));

// [testbench/dut_link_model.sv]
// Device under test: loops generator clock and data back to the analyzer.
// Assumes the generator runs at a 400 ns test clock period; ref_flip_i corrupts the reference.
`timescale 1ns/10ps
module dut_link_model
    import bert_pkg::*;
(
    input wire tx_pins_t tx_i,
    input wire logic ref_flip_i,
    output logic rx_clk_o,
    output logic rx_data_o,
    output logic rx_ref_o
);
    assign rx_clk_o = tx_i.clk;
    assign rx_data_o = tx_i.data;
    assign rx_ref_o = tx_i.data ^ ref_flip_i;
endmodule : dut_link_model

// [testbench/testbench.sv]
// Self-checking bench: Wishbone master, loopback link, pin stimulus.
// Assumes a 20 MHz clock and a DIV of 4 giving a 400 ns link clock.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module testbench;
    import bert_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic ack_o, irq_o, fault_inject_i = 0, data_inhibit_i = 0, error_inhibit_i = 0, flip = 0;
    logic rx_clk_i, rx_data_i, rx_ref_i;
    tx_pins_t tx_o;
    rx_pins_t rx_o;
    int mismatches = 0, n_tests = 0, npulse = 0;
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) if (rx_o.per_mismatch_pulse_out === 1'b1) npulse++;
    bert_aux_io bert_aux_io_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .fault_inject_i(fault_inject_i), .data_inhibit_i(data_inhibit_i),
        .tx_o(tx_o), .rx_clk_i(rx_clk_i), .rx_data_i(rx_data_i), .rx_ref_i(rx_ref_i),
        .error_inhibit_i(error_inhibit_i), .rx_o(rx_o));
    dut_link_model dut_link_model_i (.tx_i(tx_o), .ref_flip_i(flip), .rx_clk_o(rx_clk_i),
        .rx_data_o(rx_data_i), .rx_ref_o(rx_ref_i));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= a; dat_i <= d;
        do begin
            @(negedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (k >= 20) begin
            mismatches++;
            summarize();
        end
        q = dat_o;
        @(posedge clk_i);
        cyc_i <= 0; stb_i <= 0; we_i <= 0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] ex);
        wb(0, a, 32'h0);
        `CHK("read", ex, q)
    endtask : rd_chk
    task automatic clear_count();
        wb(1, REG_ERRCNT, 32'h0);
        npulse = 0;
    endtask : clear_count
    task automatic t_regs();
        rd_chk(REG_CTRL, 32'h0); rd_chk(REG_DIV, 32'h1); rd_chk(REG_MASK, 32'h0);
        rd_chk(REG_DELAY, 32'h0); rd_chk(REG_ERRCNT, 32'h0); rd_chk(8'h18, 32'h0);
        wb(1, 8'h18, 32'hFFFF_FFFF); wb(1, REG_DIV, 32'h4); rd_chk(REG_DIV, 32'h4);
    endtask : t_regs
    task automatic t_clocks();
        int nc, n2, n4;
        tx_pins_t p;
        nc = 0; n2 = 0; n4 = 0; p = tx_o;
        repeat (512) begin
            @(posedge clk_i);
            nc += int'(tx_o.clk & ~p.clk); n2 += int'(tx_o.clk_div2 & ~p.clk_div2);
            n4 += int'(tx_o.clk_div4 & ~p.clk_div4); p = tx_o;
        end
        `CHK("clk_div2", 1'b1, (nc >= 2 * n2 - 1 && nc <= 2 * n2 + 1))
        `CHK("clk_div4", 1'b1, (nc >= 4 * n4 - 2 && nc <= 4 * n4 + 2))
    endtask : t_clocks
    task automatic t_selfref();
        wb(1, REG_DELAY, 32'h0302); repeat (2400) @(posedge clk_i); clear_count();
        repeat (2400) @(posedge clk_i);
        rd_chk(REG_ERRCNT, 32'h0);
        `CHK("pulses", 0, npulse)
    endtask : t_selfref
    task automatic t_frames();
        int nts, nrs, nbad;
        tx_pins_t p;
        nts = 0; nrs = 0; nbad = 0; p = tx_o;
        // Two full frames of 127 bits at 8 clocks per bit
        repeat (2032) begin
            @(negedge clk_i);
            nts += int'(tx_o.frame_sync & ~p.frame_sync);
            nrs += int'(rx_o.frame_sync);
            if (tx_o.clk && !p.clk && tx_o.phase_a !== tx_o.data
                && tx_o.phase_b !== tx_o.data) nbad++;
            p = tx_o;
        end
        `CHK("gen sync", 2, nts)
        `CHK("rx sync", 2, nrs)
        `CHK("phase split", 0, nbad)
    endtask : t_frames
    task automatic t_inject();
        wb(1, REG_CTRL, 32'h2); wb(1, REG_MASK, 32'h4); wb(0, REG_STATUS, 32'h0); clear_count();
        `CHK("irq idle", 1'b0, irq_o)
        repeat (2) begin
            fault_inject_i <= 1; repeat (10) @(posedge clk_i);
            fault_inject_i <= 0; repeat (300) @(posedge clk_i);
        end
        rd_chk(REG_ERRCNT, 32'h6);
        `CHK("pulses", 6, npulse)
        `CHK("irq set", 1'b1, irq_o)
        wb(0, REG_STATUS, 32'h0);
        `CHK("inject status", 1'b1, q[EV_INJECT])
        `CHK("irq cleared", 1'b0, irq_o)
        wb(1, REG_CTRL, 32'h0); fault_inject_i <= 1; repeat (10) @(posedge clk_i);
        fault_inject_i <= 0; repeat (300) @(posedge clk_i);
        rd_chk(REG_ERRCNT, 32'h6);
    endtask : t_inject
    task automatic t_extref();
        wb(1, REG_CTRL, 32'h4); wb(1, REG_DELAY, 32'h0202); clear_count();
        repeat (800) @(posedge clk_i);
        rd_chk(REG_ERRCNT, 32'h0);
        flip <= 1; error_inhibit_i <= 1; repeat (10) @(posedge clk_i); clear_count();
        repeat (800) @(posedge clk_i);
        rd_chk(REG_ERRCNT, 32'h0);
        error_inhibit_i <= 0; repeat (10) @(posedge clk_i); clear_count();
        repeat (800) @(posedge clk_i); wb(0, REG_ERRCNT, 32'h0);
        `CHK("ext ref errors", 1'b1, (q >= 32'd90))
        flip <= 0;
    endtask : t_extref
    task automatic t_invert();
        wb(1, REG_CTRL, 32'h1); repeat (100) @(posedge clk_i); clear_count();
        repeat (800) @(posedge clk_i); wb(0, REG_ERRCNT, 32'h0);
        `CHK("inverted errors", 1'b1, (q >= 32'd90))
        data_inhibit_i <= 1; repeat (10) @(posedge clk_i);
        `CHK("inhibit", 3'h0, {tx_o.data, tx_o.phase_a, tx_o.phase_b})
        data_inhibit_i <= 0;
    endtask : t_invert
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        t_regs(); t_clocks(); t_selfref(); t_frames(); t_inject(); t_extref(); t_invert();
        summarize();
    end
endmodule : testbench
